// File: rtl/asf_pkg.sv
package asf_pkg;
	// flag register byte address on the core data bus; wishbone reaches it at WB_FLAG_OFS
	localparam logic [11:0] FLAG_REG_ADDR = 12'hfd8;
	localparam logic [7:0]  FLAG_RESET    = 8'h00;
	localparam int NEG_BIT = 4;
	localparam int OVF_BIT = 3;
	localparam int ZER_BIT = 2;
	localparam int NIB_BIT = 1;
	localparam int CAR_BIT = 0;
	localparam logic [7:0] FLAG_MASK = 8'h1f;
	// wishbone offsets
	localparam logic [3:0] WB_FLAG_OFS = 4'h0;
	localparam logic [3:0] WB_LAST_OFS = 4'h4;

	typedef enum logic [3:0] {
		ASF_OP_NONE  = 4'b0000,
		ASF_OP_ADD   = 4'b0001,
		ASF_OP_ADDC  = 4'b0010,
		ASF_OP_SUB   = 4'b0011,
		ASF_OP_SUBB  = 4'b0100,
		ASF_OP_AND   = 4'b0101,
		ASF_OP_IOR   = 4'b0110,
		ASF_OP_XOR   = 4'b0111,
		ASF_OP_CLR   = 4'b1000,
		ASF_OP_BCLR  = 4'b1001,
		ASF_OP_BSET  = 4'b1010,
		ASF_OP_SWAP  = 4'b1011,
		ASF_OP_FCOPY = 4'b1100,
		ASF_OP_WCOPY = 4'b1101,
		ASF_OP_MOV   = 4'b1110
	} asf_op_t;
endpackage

// File: rtl/asf_flag_reg.sv
// What this block does
// RULE_01: flags live in one register readable and writable as data memory.
// RULE_02: flag register may be source or destination of any instruction.
// RULE_03: flag-affecting op aimed at flag register writes flags, drops result.
// RULE_04: clear-file on flag register sets zero flag only, others kept.
// RULE_05: bit clear/set, swap and copies keep the arithmetic flags unless the flag register is the destination, which takes their result.
// RULE_06: subtract uses carry and nibble carry as inverted borrows.
// RULE_07: negative flag bit four follows result bit seven.
// RULE_08: overflow flag bit three marks signed two's complement overflow.
// RULE_09: zero flag bit two set when result is zero.
// RULE_10: nibble carry bit one from bit three, carry bit zero from bit seven.
// RULE_11: flags updated in the same edge, seen by the next instruction.
`timescale 1ns/10ps
`default_nettype none
module asf_flag_reg
	import asf_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        exValid,
	input  wire logic [3:0]  exOp,
	input  wire logic [7:0]  exOperandA,
	input  wire logic [7:0]  exOperandB,
	input  wire logic [2:0]  exBitSel,
	input  wire logic [11:0] exDestAddr,
	input  wire logic        exDestFile,
	input  wire logic [11:0] exSrcAddr,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [7:0]  exResult,
	output logic             exWriteEn,
	output logic      [7:0]  flags,
	output logic      [7:0]  srcData,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o
);
	import asf_pkg::*;

	logic [7:0] next_result;
	logic [4:0] next_alu;
	logic       aluFlagsValid;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] opB;
	logic       cin;
	logic [7:0] flagNext;
	logic       toFlag;
	logic [7:0] lastResult;
	logic       wbHit;

	function automatic logic isFlagging(input logic [3:0] op);
		case (op)
			ASF_OP_ADD, ASF_OP_ADDC, ASF_OP_SUB, ASF_OP_SUBB,
			ASF_OP_AND, ASF_OP_IOR, ASF_OP_XOR, ASF_OP_CLR: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	assign toFlag = exDestFile && (exDestAddr == FLAG_REG_ADDR);

	// subtraction adds the complement; carries then read as not-borrow
	always_comb begin
		opB = exOperandB;
		cin = 1'b0;
		unique case (exOp)
			ASF_OP_ADDC: cin = flags[CAR_BIT];
			ASF_OP_SUB: begin
				opB = ~exOperandB; // RULE_06
				cin = 1'b1;
			end
			ASF_OP_SUBB: begin
				opB = ~exOperandB; // RULE_06
				cin = flags[CAR_BIT];
			end
			default: ;
		endcase
		sum9 = {1'b0, exOperandA} + {1'b0, opB} + {8'h00, cin};
		sum5 = {1'b0, exOperandA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
	end

	always_comb begin
		next_result = 8'h00;
		aluFlagsValid = isFlagging(exOp);
		next_alu = flags[4:0];
		unique case (exOp)
			ASF_OP_ADD, ASF_OP_ADDC, ASF_OP_SUB, ASF_OP_SUBB: begin
				next_result = sum9[7:0];
				next_alu[CAR_BIT] = sum9[8]; // RULE_10
				next_alu[NIB_BIT] = sum5[4]; // RULE_10
				next_alu[OVF_BIT] = (exOperandA[7] == opB[7])
					&& (sum9[7] != exOperandA[7]); // RULE_08
			end
			ASF_OP_AND:   next_result = exOperandA & exOperandB;
			ASF_OP_IOR:   next_result = exOperandA | exOperandB;
			ASF_OP_XOR:   next_result = exOperandA ^ exOperandB;
			ASF_OP_CLR:   next_result = 8'h00;
			ASF_OP_BCLR:  next_result = exOperandA & ~(8'h01 << exBitSel);
			ASF_OP_BSET:  next_result = exOperandA | (8'h01 << exBitSel);
			ASF_OP_SWAP:  next_result = {exOperandA[3:0], exOperandA[7:4]};
			ASF_OP_FCOPY: next_result = exOperandA;
			ASF_OP_WCOPY: next_result = exOperandB;
			ASF_OP_MOV:   next_result = exOperandA;
			default:      next_result = 8'h00;
		endcase
		if (aluFlagsValid) begin
			next_alu[ZER_BIT] = (next_result == 8'h00); // RULE_09
			if (exOp != ASF_OP_CLR)
				next_alu[NEG_BIT] = next_result[7]; // RULE_07
		end
	end

	// wishbone write to the flag register byte lane
	logic wbWrite;
	assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wbWrite = wbHit && wb_we_i && (wb_adr_i == WB_FLAG_OFS)
		&& wb_sel_i[0];

	always_comb begin
		flagNext = flags;
		if (wbWrite)
			flagNext = wb_dat_i[7:0] & FLAG_MASK; // RULE_01
		if (exValid && toFlag) begin
			if (isFlagging(exOp))
				flagNext = {3'b000, next_alu}; // RULE_03 RULE_04
			else
				flagNext = next_result & FLAG_MASK; // RULE_02 RULE_05
		end else if (exValid && isFlagging(exOp))
			flagNext = {3'b000, next_alu};
	end

	// core writes win over a same-edge bus write
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			flags <= FLAG_RESET;
		else
			flags <= flagNext; // RULE_11
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			exResult  <= 8'h00;
			exWriteEn <= 1'b0;
		end else begin
			exResult  <= next_result;
			exWriteEn <= exValid && exDestFile && !toFlag; // RULE_03
		end
	end

	// flag register read as an operand
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			srcData <= 8'h00;
		else
			srcData <= (exSrcAddr == FLAG_REG_ADDR)
				? (flagNext & FLAG_MASK) : 8'h00; // RULE_02
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			lastResult <= 8'h00;
		else if (exValid)
			lastResult <= next_result;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			if (wbHit) begin
				if (wb_adr_i == WB_FLAG_OFS) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {24'h000000, flags & FLAG_MASK}; // RULE_01
				end else if (wb_adr_i == WB_LAST_OFS) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {24'h000000, lastResult};
				end else begin
					wb_err_o <= 1'b1;
					wb_dat_o <= 32'h0000_0000;
				end
			end
		end
	end

	// carry and sign of a plain add, worked out apart from the datapath
	logic [8:0] chkSum;
	assign chkSum = {1'b0, exOperandA} + {1'b0, exOperandB};

	// instruction and bus steps for the properties; only the add and subtract steps are shared
	sequence s_add_issue;
		exValid && exOp == ASF_OP_ADD;
	endsequence
	sequence s_addc_issue;
		exValid && exOp == ASF_OP_ADDC;
	endsequence
	sequence s_sub_issue;
		exValid && exOp == ASF_OP_SUB;
	endsequence
	sequence s_subb_issue;
		exValid && exOp == ASF_OP_SUBB;
	endsequence
	sequence s_logic_issue;
		exValid && (exOp == ASF_OP_AND || exOp == ASF_OP_IOR
			|| exOp == ASF_OP_XOR);
	endsequence
	sequence s_wb_mapped;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
			&& (wb_adr_i == WB_FLAG_OFS || wb_adr_i == WB_LAST_OFS);
	endsequence
	sequence s_wb_unmapped;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
			&& wb_adr_i != WB_FLAG_OFS && wb_adr_i != WB_LAST_OFS;
	endsequence

	a_clear_zero_only: assert property ( // RULE_04
		@(posedge clock) disable iff (!rst_n)
		exValid && toFlag && exOp == ASF_OP_CLR |=>
		flags == {3'b000, $past(flags[4:3]), 1'b1, $past(flags[1:0])})
		else $error("clear of flag register wrong");
	a_flag_dest_nowrite: assert property ( // RULE_03
		@(posedge clock) disable iff (!rst_n)
		exValid && toFlag |=> !exWriteEn)
		else $error("result written to flag register");
	a_move_keeps_flags: assert property ( // RULE_05
		@(posedge clock) disable iff (!rst_n)
		exValid && !toFlag && !wbWrite && !isFlagging(exOp)
		|=> $stable(flags))
		else $error("flags changed by non-flag op");
	a_zero_follows: assert property ( // RULE_09
		@(posedge clock) disable iff (!rst_n)
		exValid && isFlagging(exOp)
		|=> flags[ZER_BIT] == ($past(next_result) == 8'h00))
		else $error("zero flag wrong");
	a_neg_follows: assert property ( // RULE_07
		@(posedge clock) disable iff (!rst_n)
		exValid && isFlagging(exOp) && exOp != ASF_OP_CLR
		|=> flags[NEG_BIT] == $past(next_result[7]))
		else $error("negative flag wrong");
	a_sub_borrow: assert property ( // RULE_06
		@(posedge clock) disable iff (!rst_n)
		s_sub_issue
		|=> flags[CAR_BIT] == ($past(exOperandA) >= $past(exOperandB)))
		else $error("borrow polarity wrong");
	a_carry_add: assert property ( // RULE_10
		@(posedge clock) disable iff (!rst_n)
		s_add_issue |=> flags[CAR_BIT] == $past(chkSum[8]))
		else $error("carry wrong");
	a_ovf_add: assert property ( // RULE_08
		@(posedge clock) disable iff (!rst_n)
		s_add_issue |=> flags[OVF_BIT] ==
		($past(exOperandA[7]) == $past(exOperandB[7])
		&& $past(chkSum[7]) != $past(exOperandA[7])))
		else $error("overflow wrong");
	a_high_zero: assert property ( // RULE_01
		@(posedge clock) disable iff (!rst_n)
		flags[7:5] == 3'b000)
		else $error("unused flag bits set");
	a_bus_readback: assert property ( // RULE_01
		@(posedge clock) disable iff (!rst_n)
		wbWrite && !exValid
		|=> flags == ($past(wb_dat_i[7:0]) & FLAG_MASK))
		else $error("bus write lost");
	a_carry_addc: assert property ( // RULE_11
		@(posedge clock) disable iff (!rst_n)
		s_addc_issue |=> flags[CAR_BIT] ==
		(({1'b0, $past(exOperandA)} + {1'b0, $past(exOperandB)}
		+ {8'h00, $past(flags[CAR_BIT])}) > 9'h0ff))
		else $error("carry in not taken from previous result");
	a_subb_borrow: assert property ( // RULE_06
		@(posedge clock) disable iff (!rst_n)
		s_subb_issue |=> flags[CAR_BIT] ==
		({1'b0, $past(exOperandA)} >= ({1'b0, $past(exOperandB)}
		+ {8'h00, !$past(flags[CAR_BIT])})))
		else $error("borrow in polarity wrong");
	a_sub_nibble: assert property ( // RULE_06
		@(posedge clock) disable iff (!rst_n)
		s_sub_issue |=> flags[NIB_BIT] ==
		($past(exOperandA[3:0]) >= $past(exOperandB[3:0])))
		else $error("nibble borrow polarity wrong");
	a_nibble_add: assert property ( // RULE_10
		@(posedge clock) disable iff (!rst_n)
		s_add_issue |=> flags[NIB_BIT] ==
		(({1'b0, $past(exOperandA[3:0])} + {1'b0, $past(exOperandB[3:0])})
		> 5'h0f))
		else $error("nibble carry wrong");
	a_logic_keeps: assert property ( // RULE_09
		@(posedge clock) disable iff (!rst_n)
		s_logic_issue |=> flags[OVF_BIT] == $past(flags[OVF_BIT])
		&& flags[NIB_BIT] == $past(flags[NIB_BIT])
		&& flags[CAR_BIT] == $past(flags[CAR_BIT]))
		else $error("logic op disturbed carries");
	a_file_write: assert property ( // RULE_02
		@(posedge clock) disable iff (!rst_n)
		exValid && exDestFile && !toFlag |=> exWriteEn)
		else $error("file write not raised");
	a_w_dest_nowrite: assert property ( // RULE_02
		@(posedge clock) disable iff (!rst_n)
		!(exValid && exDestFile) |=> !exWriteEn)
		else $error("file write without a file destination");
	a_flag_source: assert property ( // RULE_02
		@(posedge clock) disable iff (!rst_n)
		exSrcAddr == FLAG_REG_ADDR
		|=> srcData == (flags & FLAG_MASK))
		else $error("flag register read as operand wrong");
	a_wb_ack_next: assert property ( // RULE_01
		@(posedge clock) disable iff (!rst_n)
		s_wb_mapped |=> wb_ack_o && !wb_err_o)
		else $error("bus access not acknowledged");
	a_wb_err_next: assert property ( // RULE_01
		@(posedge clock) disable iff (!rst_n)
		s_wb_unmapped |=> wb_err_o && !wb_ack_o)
		else $error("unmapped bus access not refused");
	a_wb_ack_pulse: assert property ( // RULE_01
		@(posedge clock) disable iff (!rst_n)
		wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
		else $error("bus answer held too long");
endmodule // asf_flag_reg
`default_nettype wire

// File: verif/asf_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module asf_core_model
	import asf_pkg::*;
(
	input  wire logic        clock,
	output logic             exValid,
	output logic      [3:0]  exOp,
	output logic      [7:0]  exOperandA,
	output logic      [7:0]  exOperandB,
	output logic      [2:0]  exBitSel,
	output logic      [11:0] exDestAddr,
	output logic             exDestFile,
	output logic      [11:0] exSrcAddr
);
	import asf_pkg::*;
	initial begin
		exValid = 1'b0;
		exOp = 4'h0;
		exOperandA = 8'h00;
		exOperandB = 8'h00;
		exBitSel = 3'h3;
		exDestAddr = 12'h000;
		exDestFile = 1'b1;
		exSrcAddr = 12'h000;
	end
	// one instruction, held for exactly one execute cycle
	task automatic exec(input asf_op_t op, input logic [7:0] a, b,
		input logic [11:0] dst, input logic toFile);
		@(posedge clock);
		exValid <= 1'b1;
		exOp <= op;
		exOperandA <= a;
		exOperandB <= b;
		exDestAddr <= dst;
		exDestFile <= toFile;
		exSrcAddr <= dst;
		@(posedge clock);
		exValid <= 1'b0;
		// stale operands must not be mistaken for live ones
		exOperandA <= ~a;
		exOperandB <= ~b;
	endtask
endmodule // asf_core_model
`default_nettype wire

// File: verif/alu_status_flag_register_test.sv
`timescale 1ns/10ps
`default_nettype none
module alu_status_flag_register_test;
	import asf_pkg::*;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [3:0]  wbAdr = 4'h0, wbSel = 4'h0;
	logic [31:0] wbDat = 32'h0, wbDatO;
	logic        wbAck, wbErr, exValid, exDestFile, exWriteEn;
	logic [3:0]  exOp;
	logic [7:0]  exOperandA, exOperandB, exResult, flags, srcData;
	logic [2:0]  exBitSel;
	logic [11:0] exDestAddr, exSrcAddr;
	int          miscompares = 0, numChecks = 0;
	localparam logic [11:0] OTHER = 12'h010;
	always #2 clock = ~clock;
	asf_core_model i_asf_core_model (.clock(clock), .exValid(exValid),
		.exOp(exOp), .exOperandA(exOperandA), .exOperandB(exOperandB),
		.exBitSel(exBitSel), .exDestAddr(exDestAddr),
		.exDestFile(exDestFile), .exSrcAddr(exSrcAddr));
	asf_flag_reg i_asf_flag_reg (.clock(clock), .rst_n(rst_n),
		.exValid(exValid), .exOp(exOp), .exOperandA(exOperandA),
		.exOperandB(exOperandB), .exBitSel(exBitSel),
		.exDestAddr(exDestAddr), .exDestFile(exDestFile),
		.exSrcAddr(exSrcAddr), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDat), .exResult(exResult), .exWriteEn(exWriteEn),
		.flags(flags), .srcData(srcData), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.wb_err_o(wbErr));
	task automatic chk(input string what, input logic [31:0] exp, got);
		numChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic acc(input logic we, input logic [3:0] adr,
		input logic [31:0] d, expD, input logic expErr);
		@(posedge clock);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbDat <= d;
		wbSel <= 4'hf;
		do begin
			@(posedge clock);
		end while (wbAck !== 1'b1 && wbErr !== 1'b1);
		if (!we && !expErr) chk("wb read", expD, wbDatO);
		chk("wb err", {31'h0, expErr}, {31'h0, wbErr});
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbDat <= ~d;
	endtask
	task automatic run(input asf_op_t op, input logic [7:0] a, b,
		input logic [11:0] dst, input logic [7:0] expF, expR);
		i_asf_core_model.exec(op, a, b, dst, dst != 12'h000);
		#1;
		chk("flags", {24'h0, expF}, {24'h0, flags});
		chk("write en", {31'h0, dst != FLAG_REG_ADDR && dst != 12'h000},
			{31'h0, exWriteEn});
		chk("source", {24'h0, (dst == FLAG_REG_ADDR) ? expF : 8'h00},
			{24'h0, srcData});
		if (dst != FLAG_REG_ADDR) chk("result", {24'h0, expR}, {24'h0, exResult});
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		finish_test;
	end
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		acc(1'b0, WB_FLAG_OFS, 32'h0, {24'h0, FLAG_RESET}, 1'b0);
		acc(1'b1, WB_FLAG_OFS, 32'hff, 32'h0, 1'b0);
		acc(1'b0, WB_FLAG_OFS, 32'h0, 32'h1f, 1'b0);
		acc(1'b0, 4'h8, 32'h0, 32'h0, 1'b1);
		$display("test register access done");
		run(ASF_OP_ADD, 8'h7f, 8'h01, OTHER, 8'h1a, 8'h80);
		run(ASF_OP_ADD, 8'hff, 8'h01, OTHER, 8'h07, 8'h00);
		run(ASF_OP_SUB, 8'h00, 8'h01, OTHER, 8'h10, 8'hff);
		run(ASF_OP_SUB, 8'h05, 8'h03, OTHER, 8'h03, 8'h02);
		run(ASF_OP_AND, 8'hf0, 8'h0f, OTHER, 8'h07, 8'h00);
		$display("test arithmetic done");
		run(ASF_OP_ADD, 8'h01, 8'h01, FLAG_REG_ADDR, 8'h00, 8'h00);
		acc(1'b1, WB_FLAG_OFS, 32'h13, 32'h0, 1'b0);
		run(ASF_OP_CLR, 8'h13, 8'h00, FLAG_REG_ADDR, 8'h17, 8'h00);
		acc(1'b1, WB_FLAG_OFS, 32'h15, 32'h0, 1'b0);
		run(ASF_OP_BCLR, 8'hff, 8'h00, OTHER, 8'h15, 8'hf7);
		run(ASF_OP_BSET, 8'h00, 8'h00, OTHER, 8'h15, 8'h08);
		run(ASF_OP_SWAP, 8'h3c, 8'h00, OTHER, 8'h15, 8'hc3);
		run(ASF_OP_FCOPY, 8'h5a, 8'h00, OTHER, 8'h15, 8'h5a);
		run(ASF_OP_WCOPY, 8'h00, 8'h66, OTHER, 8'h15, 8'h66);
		run(ASF_OP_BSET, 8'h15, 8'h00, FLAG_REG_ADDR, 8'h1d, 8'h1d);
		$display("test flag register target done");
		run(ASF_OP_ADDC, 8'h10, 8'h20, OTHER, 8'h00, 8'h31);
		run(ASF_OP_SUBB, 8'h10, 8'h01, OTHER, 8'h01, 8'h0e);
		run(ASF_OP_IOR, 8'h80, 8'h01, OTHER, 8'h11, 8'h81);
		run(ASF_OP_XOR, 8'h5a, 8'h5a, OTHER, 8'h05, 8'h00);
		run(ASF_OP_MOV, 8'h42, 8'h00, OTHER, 8'h05, 8'h42);
		run(ASF_OP_ADD, 8'h01, 8'h02, 12'h000, 8'h00, 8'h03);
		acc(1'b1, WB_LAST_OFS, 32'hff, 32'h0, 1'b0);
		acc(1'b0, WB_LAST_OFS, 32'h0, 32'h03, 1'b0);
		$display("test carry chain and result port done");
		finish_test;
	end
endmodule // alu_status_flag_register_test
`default_nettype wire
